//--- rtl/ivc_pkg.sv
`default_nettype none
package ivc_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_W       = 8;
  localparam int unsigned PC_W        = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned PTR_W       = 3;
  localparam int unsigned PERIPH_W    = 8;
  localparam int unsigned CTL_EVT_W   = 2;

  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

  // Register byte offsets on the slave bus.
  localparam logic [ADDR_W-1:0] OFF_CTL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PFLAG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PEN   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ISTS  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h14;

  // Control register layout: enables above, matching flags below.
  localparam int unsigned CTL_GIE_BIT  = 7;
  localparam int unsigned CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT = 6;
  localparam int unsigned CTL_EN_LSB   = 3;
  localparam int unsigned CTL_FLAG_LSB = 0;
  localparam int unsigned CTL_SRC_W    = 3;

  // Block status register bits.
  localparam int unsigned ISTS_TAKEN  = 0;
  localparam int unsigned ISTS_RETURN = 1;
  localparam int unsigned ISTS_HELD   = 2;
  localparam int unsigned ISTS_W      = 3;

  localparam logic [REG_W-1:0]  CTL_RST   = 8'h00;
  localparam logic [REG_W-1:0]  PFLAG_RST = 8'h00;
  localparam logic [REG_W-1:0]  PEN_RST   = 8'h00;
  localparam logic [ISTS_W-1:0] ISTS_RST  = 3'h0;
  localparam logic [ISTS_W-1:0] IMASK_RST = 3'h0;

  // Four core clocks make one instruction cycle.
  localparam logic [1:0] PHASE_LAST = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    IVC_ST_IDLE = 2'b00,
    IVC_ST_NOP1 = 2'b01,
    IVC_ST_NOP2 = 2'b10
  } ivc_state_type;
endpackage
`default_nettype wire

//--- rtl/ivc_stack_if.sv
`default_nettype none
interface ivc_stack_if;
  import ivc_pkg::*;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] wdata;
  logic [PC_W-1:0] top;
  modport ctrl  (output push, output pop, output wdata, input top);
  modport store (input push, input pop, input wdata, output top);
endinterface
`default_nettype wire

//--- rtl/ivc_stack.sv
`default_nettype none
module ivc_stack (
  // Clock and reset
  input wire logic    core_clk,
  input wire logic    resetn,
  // Push and pop port
  ivc_stack_if.store  stk
);
  import ivc_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0]                  ptr;
    logic [STACK_DEPTH-1:0][PC_W-1:0]  mem;
  } ivc_stack_state_type;

  ivc_stack_state_type q;
  ivc_stack_state_type n;

  // The pointer simply wraps, so a ninth push lands on the oldest entry.
  always_comb begin
    n = q;
    if (stk.push) begin
      n.mem[q.ptr] = stk.wdata;
      n.ptr        = PTR_W'(q.ptr + 1'b1);
    end else if (stk.pop) begin
      n.ptr = PTR_W'(q.ptr - 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign stk.top = q.mem[PTR_W'(q.ptr - 1'b1)];
endmodule // ivc_stack
`default_nettype wire

//--- rtl/ivc_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module ivc_top (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  // AXI4-Lite write address and data
  input  wire logic [ivc_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [ivc_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ivc_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [ivc_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Core fetch side
  input  wire logic [ivc_pkg::PC_W-1:0]      core_pc_next,
  input  wire logic                          core_busy,
  input  wire logic                          core_return_from_interrupt,
  output logic                               core_cycle_stb,
  output logic                               core_flush,
  output logic                               core_pc_load,
  output logic [ivc_pkg::PC_W-1:0]           core_pc_value,
  // Event sources
  input  wire logic [ivc_pkg::CTL_EVT_W-1:0] ctl_evt,
  input  wire logic                          ext_irq_pin,
  input  wire logic [ivc_pkg::PERIPH_W-1:0]  periph_evt,
  // System interrupt
  output logic                               irq
);
  import ivc_pkg::*;

  typedef struct packed {
    logic [1:0]          phase;
    logic                cyc_stb;
    logic                ext_s1;
    logic                ext_s2;
    logic                ext_s3;
    logic [REG_W-1:0]    ctl;
    logic [PERIPH_W-1:0] pflag;
    logic [PERIPH_W-1:0] pen;
    logic [ISTS_W-1:0]   ists;
    logic [ISTS_W-1:0]   imask;
    ivc_state_type       st;
    logic                flush;
    logic                pc_load;
    logic [PC_W-1:0]     pc_val;
    logic                irq;
    logic                awready;
    logic                wready;
    logic                arready;
    logic [ADDR_W-1:0]   awaddr;
    logic [REG_W-1:0]    wdata;
    logic                wstrb0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [REG_W-1:0]    rdata;
  } ivc_top_state_type;

  localparam ivc_top_state_type RST_STATE = '{
    phase:   2'h0,
    cyc_stb: 1'b0,
    ext_s1:  1'b0,
    ext_s2:  1'b0,
    ext_s3:  1'b0,
    ctl:     CTL_RST,
    pflag:   PFLAG_RST,
    pen:     PEN_RST,
    ists:    ISTS_RST,
    imask:   IMASK_RST,
    st:      IVC_ST_IDLE,
    flush:   1'b0,
    pc_load: 1'b0,
    pc_val:  13'h0000,
    irq:     1'b0,
    awready: 1'b1,
    wready:  1'b1,
    arready: 1'b1,
    awaddr:  8'h00,
    wdata:   8'h00,
    wstrb0:  1'b0,
    bvalid:  1'b0,
    bresp:   RESP_OKAY,
    rvalid:  1'b0,
    rresp:   RESP_OKAY,
    rdata:   8'h00
  };

  ivc_top_state_type q;
  ivc_top_state_type n;

  ivc_stack_if stk_if ();

  ivc_stack u_stack (
    .core_clk (core_clk),
    .resetn   (resetn),
    .stk      (stk_if.store)
  );

  logic                 ext_edge;
  logic [CTL_SRC_W-1:0] src_set;
  logic [CTL_SRC_W-1:0] ctl_en;
  logic                 global_irq_enable;
  logic                 peripheral_group_irq_enable;
  logic                 pending;
  logic                 fresh_enabled;
  logic                 take;
  logic                 ret;
  logic                 wr_go;
  logic                 aw_go;
  logic                 w_go;
  logic                 b_done;
  logic                 r_go;
  logic                 r_done;
  logic                 at_boundary;
  logic                 core_free;
  logic [CTL_SRC_W-1:0] ctl_hit;
  logic [CTL_SRC_W-1:0] ctl_new;
  logic [PERIPH_W-1:0]  periph_hit;
  logic [PERIPH_W-1:0]  periph_new;

  // The third flop only serves the edge detector on the settled copy.
  assign ext_edge = q.ext_s2 & ~q.ext_s3;
  assign src_set  = {ctl_evt[1], ext_edge, ctl_evt[0]};
  assign ctl_en   = q.ctl[CTL_EN_LSB +: CTL_SRC_W];
  assign global_irq_enable      = q.ctl[CTL_GIE_BIT];
  assign peripheral_group_irq_enable     = q.ctl[CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT];

  // Each control source is gated by its own enable only.
  for (genvar gi = 0; gi < CTL_SRC_W; gi++) begin : g_ctl_src
    assign ctl_hit[gi] = q.ctl[CTL_FLAG_LSB + gi] & ctl_en[gi];
    assign ctl_new[gi] = src_set[gi] & ctl_en[gi];
  end

  // Peripheral sources need the group enable on top of their own enable.
  for (genvar gp = 0; gp < PERIPH_W; gp++) begin : g_periph_src
    assign periph_hit[gp] = peripheral_group_irq_enable & q.pflag[gp] & q.pen[gp];
    assign periph_new[gp] = peripheral_group_irq_enable & periph_evt[gp] & q.pen[gp];
  end

  // A flag left standing keeps this high, which is why software must clear it.
  assign pending = global_irq_enable && ((|ctl_hit) || (|periph_hit));

  assign fresh_enabled = (|ctl_new) || (|periph_new);

  // Decisions are made only at an instruction boundary, never mid-instruction.
  assign at_boundary = q.cyc_stb && (q.st == IVC_ST_IDLE);
  assign core_free   = !core_busy && !core_return_from_interrupt;
  assign take        = at_boundary && pending && core_free;
  assign ret         = at_boundary && core_return_from_interrupt;

  // A new write waits for a free response slot, so no response is ever overwritten.
  assign wr_go  = !q.awready && !q.wready && !q.bvalid;
  assign aw_go  = s_axi_awvalid && q.awready;
  assign w_go   = s_axi_wvalid && q.wready;
  assign b_done = q.bvalid && s_axi_bready;
  assign r_go   = s_axi_arvalid && q.arready;
  assign r_done = q.rvalid && s_axi_rready;

  // The push uses the address seen at the decision edge, before the core moves on.
  assign stk_if.push  = take;
  assign stk_if.wdata = core_pc_next;
  assign stk_if.pop   = ret;

  always_comb begin
    n = q;
    n.pc_load = 1'b0;
    // The free-running phase counter makes the one-cycle instruction strobe.
    n.phase   = 2'(q.phase + 2'h1);
    n.cyc_stb = (q.phase == PHASE_LAST);
    n.ext_s1  = ext_irq_pin;
    n.ext_s2  = q.ext_s1;
    n.ext_s3  = q.ext_s2;

    // Write address and data are captured independently.
    if (aw_go) begin
      n.awaddr  = s_axi_awaddr;
      n.awready = 1'b0;
    end
    if (w_go) begin
      n.wdata   = s_axi_wdata[REG_W-1:0];
      n.wstrb0  = s_axi_wstrb[0];
      n.wready  = 1'b0;
    end
    if (wr_go) begin
      n.awready = 1'b1;
      n.wready  = 1'b1;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      case (q.awaddr)
        OFF_CTL: begin
          if (q.wstrb0) begin
            n.ctl = q.wdata;
          end
        end
        OFF_PFLAG: begin
          if (q.wstrb0) begin
            n.pflag = q.wdata;
          end
        end
        OFF_PEN: begin
          if (q.wstrb0) begin
            n.pen = q.wdata;
          end
        end
        OFF_ISTS: begin
          if (q.wstrb0) begin
            n.ists = q.ists & ~q.wdata[ISTS_W-1:0];
          end
        end
        OFF_IMASK: begin
          if (q.wstrb0) begin
            n.imask = q.wdata[ISTS_W-1:0];
          end
        end
        OFF_STATE: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end else if (b_done) begin
      n.bvalid = 1'b0;
    end

    // Reads are answered from registered state one cycle after the address is taken.
    if (r_go) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTL: begin
          n.rdata = q.ctl;
        end
        OFF_PFLAG: begin
          n.rdata = q.pflag;
        end
        OFF_PEN: begin
          n.rdata = q.pen;
        end
        OFF_ISTS: begin
          n.rdata = {5'h00, q.ists};
        end
        OFF_IMASK: begin
          n.rdata = {5'h00, q.imask};
        end
        OFF_STATE: begin
          n.rdata = {4'h0, q.flush, pending, q.st};
        end
        default: begin
          n.rdata = 8'h00;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end else if (r_done) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // Hardware sets come after the software write, so a set always wins.
    n.ctl[CTL_FLAG_LSB +: CTL_SRC_W] = n.ctl[CTL_FLAG_LSB +: CTL_SRC_W] | src_set;
    n.pflag = n.pflag | periph_evt;

    // Entry takes two flushed cycles before the vector is fetched.
    case (q.st)
      IVC_ST_IDLE: begin
        if (take) begin
          n.st               = IVC_ST_NOP1;
          n.flush            = 1'b1;
          n.ctl[CTL_GIE_BIT] = 1'b0;
          n.ists[ISTS_TAKEN] = 1'b1;
        end else if (ret) begin
          n.pc_load          = 1'b1;
          n.pc_val           = stk_if.top;
          n.ctl[CTL_GIE_BIT] = 1'b1;
          n.ists[ISTS_RETURN] = 1'b1;
        end
      end
      IVC_ST_NOP1: begin
        if (q.cyc_stb) begin
          n.st = IVC_ST_NOP2;
        end
      end
      IVC_ST_NOP2: begin
        if (q.cyc_stb) begin
          n.st      = IVC_ST_IDLE;
          n.flush   = 1'b0;
          n.pc_load = 1'b1;
          n.pc_val  = IRQ_VECTOR;
        end
      end
      default: begin
        n.st    = IVC_ST_IDLE;
        n.flush = 1'b0;
      end
    endcase

    if (!global_irq_enable && fresh_enabled) begin
      n.ists[ISTS_HELD] = 1'b1;
    end

    // The output follows the next status, so it never lags a clear by a cycle.
    n.irq = |(n.ists & n.imask);
  end

  // Reset clears the global enable along with the other state, but sets the three ready flags.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= RST_STATE;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready  = q.awready;
  assign s_axi_wready   = q.wready;
  assign s_axi_bresp    = q.bresp;
  assign s_axi_bvalid   = q.bvalid;
  assign s_axi_arready  = q.arready;
  assign s_axi_rdata    = {24'h000000, q.rdata};
  assign s_axi_rresp    = q.rresp;
  assign s_axi_rvalid   = q.rvalid;
  assign core_cycle_stb = q.cyc_stb;
  assign core_flush     = q.flush;
  assign core_pc_load   = q.pc_load;
  assign core_pc_value  = q.pc_val;
  assign irq            = q.irq;
endmodule // ivc_top
`default_nettype wire

//--- bench/ivc_core_model.sv
`default_nettype none
module ivc_core_model (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // From the vectoring block
  input  wire logic                     core_cycle_stb,
  input  wire logic                     core_flush,
  input  wire logic                     core_pc_load,
  input  wire logic [ivc_pkg::PC_W-1:0] core_pc_value,
  // Bench requests
  input  wire logic                     ret_req,
  input  wire logic                     busy_req,
  // To the vectoring block
  output logic      [ivc_pkg::PC_W-1:0] core_pc_next,
  output logic                          core_busy,
  output logic                          core_return_from_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  import ivc_pkg::*;
  logic ret_q;
  // A held instruction does not advance the PC, so the pushed address stays put.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      core_pc_next <= 13'h0000;
      ret_q        <= 1'b0;
    end else begin
      if (core_pc_load)
        core_pc_next <= core_pc_value;
      else if (core_cycle_stb && !core_flush && !core_busy)
        core_pc_next <= core_pc_next + 13'h0001;
      if (ret_req)
        ret_q <= 1'b1;
      else if (core_cycle_stb)
        ret_q <= 1'b0;
    end
  end
  assign core_busy   = busy_req;
  assign core_return_from_interrupt = ret_q & core_cycle_stb;
endmodule // ivc_core_model
`default_nettype wire

//--- bench/ivc_checker.sv
`default_nettype none
module ivc_checker (
  // Clock and reset
  input wire logic                     core_clk,
  input wire logic                     resetn,
  // Register bus
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [31:0]              s_axi_rdata,
  // Core side
  input wire logic                     core_busy,
  input wire logic                     core_return_from_interrupt,
  input wire logic                     core_cycle_stb,
  input wire logic                     core_flush,
  input wire logic                     core_pc_load,
  input wire logic [ivc_pkg::PC_W-1:0] core_pc_value,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import ivc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property ($rose(resetn) |-> !irq && s_axi_awready && !core_flush [*5])
    else $error("activity right after reset");
  a_flush_span: assert property ($rose(core_flush) |-> core_flush [*8])
    else $error("flush shorter than two instruction cycles");
  a_vector_load: assert property ($rose(core_flush) |->
    ##[8:9] (core_pc_load && core_pc_value == IRQ_VECTOR))
    else $error("vector not loaded after flush");
  a_load_cause: assert property (core_pc_load |-> $past(core_flush, 2) || $past(core_return_from_interrupt))
    else $error("pc load without entry or return");
  a_return_load: assert property (core_return_from_interrupt && !core_flush && !$past(core_flush)
    |=> core_pc_load)
    else $error("return did not load pc");
  a_busy_hold: assert property (core_cycle_stb && core_busy |=> !$rose(core_flush))
    else $error("entry during busy instruction");
  a_stb_period: assert property (core_cycle_stb |=> !core_cycle_stb [*3] ##1 core_cycle_stb)
    else $error("instruction strobe period wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  c_entry: cover property ($rose(core_flush));
  c_return: cover property (core_return_from_interrupt && core_cycle_stb);
  c_irq: cover property ($rose(irq));
endmodule // ivc_checker
`default_nettype wire

//--- bench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ivc_pkg::*;
  logic        core_clk = 0, resetn = 0, ret_req = 0, busy_req = 0, ext_irq_pin = 0, fl_q = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq, core_busy, core_return_from_interrupt, core_cycle_stb, core_flush, core_pc_load;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, periph_evt = 0, pv;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ctl_evt = 0;
  logic [12:0] core_pc_next, core_pc_value, stb_pc = 0, lval = 0;
  logic [12:0] stk[$];
  int          errors = 0, comparisons = 0, loads = 0, n;

  always #5 core_clk = ~core_clk;

  ivc_top u_dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_pc_next, .core_busy,
    .core_return_from_interrupt, .core_cycle_stb, .core_flush, .core_pc_load, .core_pc_value, .ctl_evt,
    .ext_irq_pin, .periph_evt, .irq);
  ivc_core_model u_core (.core_clk, .resetn, .core_cycle_stb, .core_flush, .core_pc_load,
    .core_pc_value, .ret_req, .busy_req, .core_pc_next, .core_busy, .core_return_from_interrupt);

  // The expected stack keeps only the newest eight pushes, as the hardware overwrites.
  always @(negedge core_clk) begin
    if (core_cycle_stb && !core_flush)
      stb_pc = core_pc_next;
    if (core_flush && !fl_q)
      stk.push_back(stb_pc);
    if (stk.size() > STACK_DEPTH)
      stk.pop_front();
    fl_q = core_flush;
    if (core_pc_load) begin
      loads++;
      lval = core_pc_value;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, tk;
    logic [1:0] rs;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge core_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tk) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    chk(rs, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
    logic ta, tk;
    logic [1:0] rs;
    logic [31:0] dt;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge core_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid & s_axi_rready;
      rs = s_axi_rresp;
      dt = s_axi_rdata;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tk) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    chk(dt, ed);
    chk(rs, er);
  endtask

  // Waits until a pc load is seen or the limit runs out; inc says how many are expected.
  task automatic wl(input int lim, input int inc);
    int l0;
    l0 = loads;
    n = 0;
    while (loads == l0 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk(loads, l0 + inc);
  endtask

  task automatic ret();
    @(posedge core_clk);
    ret_req <= 1'b1;
    @(posedge core_clk);
    ret_req <= 1'b0;
    wl(20, 1);
    chk(lval, stk.pop_back());
  endtask

  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #200us;
    errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hf89e14b5));
    pv = 8'($urandom) | 8'h01;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    rd(OFF_CTL, 32'h0);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 8'hff, RESP_SLVERR);
    @(posedge core_clk);
    periph_evt <= pv;
    ctl_evt <= 2'h3;
    ext_irq_pin <= 1'b1;
    @(posedge core_clk);
    periph_evt <= 8'h00;
    ctl_evt <= 2'h0;
    repeat (6) @(posedge core_clk);
    ext_irq_pin <= 1'b0;
    rd(OFF_CTL, 32'h07);
    rd(OFF_PFLAG, {24'h0, pv});
    wr(OFF_CTL, 8'h3f);
    ctl_evt <= 2'h2;
    @(posedge core_clk);
    ctl_evt <= 2'h0;
    wl(30, 0);
    rd(OFF_ISTS, 32'h04);
    wr(OFF_PEN, pv);
    wr(OFF_IMASK, 8'h01);
    for (int i = 0; i < 9; i++) begin
      wr(OFF_CTL, 8'hbf);
      wl(40, 1);
      chk(lval, IRQ_VECTOR);
    end
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b1);
    wr(OFF_IMASK, 8'h00);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b0);
    wr(OFF_IMASK, 8'h01);
    wr(OFF_ISTS, 8'h07);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b0);
    wr(OFF_CTL, 8'h00);
    repeat (8) ret();
    rd(OFF_CTL, 32'h80);
    rd(OFF_ISTS, 32'h02);
    wl(30, 0);
    wr(OFF_CTL, 8'hc0);
    wl(40, 1);
    rd(OFF_PFLAG, {24'h0, pv});
    wr(OFF_PFLAG, 8'h00);
    ret();
    wr(OFF_CTL, 8'h88);
    @(posedge core_clk);
    ctl_evt <= 2'h1;
    @(posedge core_clk);
    ctl_evt <= 2'h0;
    wl(16, 1);
    wr(OFF_CTL, 8'h00);
    ret();
    busy_req <= 1'b1;
    wr(OFF_CTL, 8'h89);
    wl(30, 0);
    rd(OFF_STATE, 32'h04);
    busy_req <= 1'b0;
    wl(20, 1);
    wr(OFF_CTL, 8'h00);
    ret();
    wr(OFF_CTL, 8'h90);
    @(posedge core_clk);
    ext_irq_pin <= 1'b1;
    wl(20, 1);
    ext_irq_pin <= 1'b0;
    resetn <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rd(OFF_CTL, 32'h0);
    end_of_test();
  end
endmodule // tb

bind ivc_top ivc_checker u_chk (.core_clk(core_clk), .resetn(resetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .core_busy(core_busy), .core_return_from_interrupt(core_return_from_interrupt),
  .core_cycle_stb(core_cycle_stb), .core_flush(core_flush), .core_pc_load(core_pc_load),
  .core_pc_value(core_pc_value), .irq(irq));
`default_nettype wire
